// File: agrm_app_model.sv
`timescale 1ns/1ps
`default_nettype none
module agrm_app_model (
  // Clock
  input  wire logic        clk,
  // Values from the input registers
  input  wire logic [15:0] inFirst,
  input  wire logic [15:0] inSecond,
  // Values into the output registers
  output var logic  [15:0] outFirst,
  output var logic  [15:0] outSecond
);
  // Registered so that the captured value lags, as real downstream logic does.
  always_ff @(posedge clk) begin
    outFirst  <= ~inSecond;
    outSecond <= inFirst;
  end
endmodule : agrm_app_model
`default_nettype wire

// File: agrm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module agrm_asserts
  import agrm_pkg::*;
#(
  parameter int PortWidth = PORT_W
) (
  // Clock, reset and enable
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 ce,
  // Input group slave port
  input wire logic [ADDR_W-1:0]    inAwaddr,
  input wire logic                 inAwvalid,
  input wire logic                 inWvalid,
  input wire logic                 inAwready,
  input wire logic                 inWready,
  input wire logic                 inBvalid,
  input wire logic                 inBready,
  input wire logic [DATA_W-1:0]    inWdata,
  input wire logic [DATA_W-1:0]    inRdata,
  input wire logic [3:0]           inWstrb,
  input wire logic                 inArvalid,
  input wire logic                 inArready,
  input wire logic                 inRvalid,
  input wire logic                 inRready,
  // Output group and design side
  input wire logic                 outBvalid,
  input wire logic [1:0]           outBresp,
  input wire logic [PortWidth-1:0] inputPortWordFirst,
  input wire logic [PortWidth-1:0] inputPortWordSecond
);
  // ****************************************************************
  // Handshake and register checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [DATA_W-1:0] wdPrev;
  // Write data one edge back, to compare against the port after the write lands.
  always_ff @(posedge clk) wdPrev <= inWdata;
  sequence wrTake;
    ce && inAwvalid && inWvalid && !inBvalid && !inAwready;
  endsequence
  sequence rdTake;
    ce && inArvalid && !inRvalid && !inArready;
  endsequence
  a_write_answer_timing: assert property (
    wrTake |=> inAwready && inWready && inBvalid) else $error("write answer late");
  a_write_port_update: assert property (
    wrTake ##0 (inAwaddr[2] == 1'b0 && inWstrb == 4'hF)
    |=> inputPortWordFirst == wdPrev[PortWidth-1:0]) else $error("port not updated");
  a_bvalid_held: assert property (
    inBvalid && !(inBready && ce) |=> inBvalid) else $error("bvalid dropped early");
  a_read_answer_timing: assert property (
    rdTake |=> inArready && inRvalid) else $error("read answer late");
  a_rvalid_data_held: assert property (
    inRvalid && !(inRready && ce) |=> inRvalid && $stable(inRdata)) else $error("rdata moved");
  a_rdata_upper_zero: assert property (
    inRvalid |-> inRdata[DATA_W-1:PortWidth] == '0) else $error("upper bits not zero");
  a_out_write_refused: assert property (
    outBvalid |-> outBresp == RESP_SLVERR) else $error("read-only write accepted");
  a_ce_low_hold: assert property (
    !ce |=> $stable(inputPortWordFirst) && $stable(inputPortWordSecond)) else $error("ce ignored");
  a_reset_clears_all: assert property (disable iff (1'b0) rst |=> !inBvalid && !inRvalid
    && inputPortWordFirst == '0 && inputPortWordSecond == '0) else $error("reset not clean");
endmodule : agrm_asserts
bind axil_gateway_register_map agrm_asserts #(.PortWidth(PortWidth)) i_agrm_asserts (
  .clk, .rst, .ce, .inAwaddr, .inAwvalid, .inWvalid, .inAwready, .inWready, .inBvalid,
  .inBready, .inWdata, .inRdata, .inWstrb, .inArvalid, .inArready, .inRvalid, .inRready,
  .outBvalid, .outBresp, .inputPortWordFirst, .inputPortWordSecond);
`default_nettype wire

// File: agrm_pkg.sv
`default_nettype none
package agrm_pkg;

  // ****************************************************************
  // Register map of each slave interface
  // ****************************************************************
  localparam logic [2:0] OFS_WORD_FIRST  = 3'h0;
  localparam logic [2:0] OFS_WORD_SECOND = 3'h4;
  localparam int         ADDR_W          = 3;
  localparam int         DATA_W          = 32;
  localparam int         PORT_W          = 16;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // One AXI4-Lite slave's outputs travel together.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } agrm_slv_out_t;

endpackage : agrm_pkg
`default_nettype wire

// File: axil_gateway_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module axil_gateway_register_map
  import agrm_pkg::*;
#(
  parameter int PortWidth = PORT_W
) (
  // Clock, reset and enable
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Input group slave port, writes and reads
  input  wire logic [ADDR_W-1:0]    inAwaddr,
  input  wire logic                 inAwvalid,
  output logic                      inAwready,
  input  wire logic [DATA_W-1:0]    inWdata,
  input  wire logic [3:0]           inWstrb,
  input  wire logic                 inWvalid,
  output logic                      inWready,
  output logic [1:0]                inBresp,
  output logic                      inBvalid,
  input  wire logic                 inBready,
  input  wire logic [ADDR_W-1:0]    inAraddr,
  input  wire logic                 inArvalid,
  output logic                      inArready,
  output logic [DATA_W-1:0]         inRdata,
  output logic [1:0]                inRresp,
  output logic                      inRvalid,
  input  wire logic                 inRready,
  // Output group slave port, reads only
  input  wire logic [ADDR_W-1:0]    outAwaddr,
  input  wire logic                 outAwvalid,
  output logic                      outAwready,
  input  wire logic [DATA_W-1:0]    outWdata,
  input  wire logic [3:0]           outWstrb,
  input  wire logic                 outWvalid,
  output logic                      outWready,
  output logic [1:0]                outBresp,
  output logic                      outBvalid,
  input  wire logic                 outBready,
  input  wire logic [ADDR_W-1:0]    outAraddr,
  input  wire logic                 outArvalid,
  output logic                      outArready,
  output logic [DATA_W-1:0]         outRdata,
  output logic [1:0]                outRresp,
  output logic                      outRvalid,
  input  wire logic                 outRready,
  // Design side
  output logic [PortWidth-1:0]      inputPortWordFirst,
  output logic [PortWidth-1:0]      inputPortWordSecond,
  input  wire logic [PortWidth-1:0] outputPortWordFirst,
  input  wire logic [PortWidth-1:0] outputPortWordSecond
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Offsets are word aligned, so the low two address bits never matter.
  // Both maps are fixed when the block is built, so a clash cannot reach this decode.
  // first word zero
  function automatic logic [1:0] agrmDecode(input logic [ADDR_W-1:0] a);
    logic [1:0] hit;
    hit = 2'h0;
    if (a[ADDR_W-1:2] == OFS_WORD_FIRST[ADDR_W-1:2]) begin
      hit = 2'h1;
    end else if (a[ADDR_W-1:2] == OFS_WORD_SECOND[ADDR_W-1:2]) begin
      hit = 2'h2;
    end
    return hit;
  endfunction : agrmDecode

  // Only the port's own bits survive, so every read shows zero above them.
  // A port of a full word or wider is not supported, as the fill would vanish.
  // port under word
  function automatic logic [DATA_W-1:0] agrmZext(input logic [PortWidth-1:0] v);
    return {{(DATA_W-PortWidth){1'b0}}, v};
  endfunction : agrmZext

  // ****************************************************************
  // State
  // ****************************************************************
  logic [DATA_W-1:0] inReg0_q, inReg0_d, inReg1_q, inReg1_d;
  logic [DATA_W-1:0] outCap0_q, outCap0_d, outCap1_q, outCap1_d;
  agrm_slv_out_t     inSlv_q, inSlv_d, outSlv_q, outSlv_d;
  logic [PortWidth-1:0] inPort0_q, inPort0_d, inPort1_q, inPort1_d;

  // Register file and both slave handshakes computed together.
  always_comb begin
    logic [1:0] wHit;
    logic [1:0] rHit;
    logic [1:0] oHit;
    wHit      = agrmDecode(inAwaddr);
    rHit      = agrmDecode(inAraddr);
    oHit      = agrmDecode(outAraddr);
    inReg0_d  = inReg0_q;
    inReg1_d  = inReg1_q;
    outCap0_d = outCap0_q;
    outCap1_d = outCap1_q;
    inSlv_d   = inSlv_q;
    outSlv_d  = outSlv_q;
    inPort0_d = inPort0_q;
    inPort1_d = inPort1_q;
    if (rst) begin
      inReg0_d  = RESET_VALUE;
      inReg1_d  = RESET_VALUE;
      outCap0_d = RESET_VALUE;
      outCap1_d = RESET_VALUE;
      inSlv_d   = '0;
      outSlv_d  = '0;
      inPort0_d = '0;
      inPort1_d = '0;
    end else if (ce) begin
      outCap0_d = agrmZext(outputPortWordFirst);
      outCap1_d = agrmZext(outputPortWordSecond);
      inSlv_d.awready = 1'b0;
      inSlv_d.wready  = 1'b0;
      if (inBready && inSlv_q.bvalid) begin
        inSlv_d.bvalid = 1'b0;
      end
      // Address and data are taken together so one accept pulse finishes a write.
      if (inAwvalid && inWvalid && !inSlv_q.bvalid && !inSlv_q.awready) begin
        inSlv_d.awready = 1'b1;
        inSlv_d.wready  = 1'b1;
        inSlv_d.bvalid  = 1'b1;
        inSlv_d.bresp   = (wHit == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (inWstrb[b] && wHit == 2'h1) begin
            inReg0_d[8*b +: 8] = inWdata[8*b +: 8];
          end
          if (inWstrb[b] && wHit == 2'h2) begin
            inReg1_d[8*b +: 8] = inWdata[8*b +: 8];
          end
        end
      end
      inSlv_d.arready = 1'b0;
      if (inRready && inSlv_q.rvalid) begin
        inSlv_d.rvalid = 1'b0;
      end
      if (inArvalid && !inSlv_q.rvalid && !inSlv_q.arready) begin
        inSlv_d.arready = 1'b1;
        inSlv_d.rvalid  = 1'b1;
        inSlv_d.rresp   = (rHit == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        inSlv_d.rdata   = (rHit == 2'h1) ? agrmZext(inReg0_q[PortWidth-1:0]) :
                          (rHit == 2'h2) ? agrmZext(inReg1_q[PortWidth-1:0]) : RESET_VALUE;
      end
      outSlv_d.awready = 1'b0;
      outSlv_d.wready  = 1'b0;
      if (outBready && outSlv_q.bvalid) begin
        outSlv_d.bvalid = 1'b0;
      end
      if (outAwvalid && outWvalid && !outSlv_q.bvalid && !outSlv_q.awready) begin
        outSlv_d.awready = 1'b1;
        outSlv_d.wready  = 1'b1;
        outSlv_d.bvalid  = 1'b1;
        outSlv_d.bresp   = RESP_SLVERR;
      end
      outSlv_d.arready = 1'b0;
      if (outRready && outSlv_q.rvalid) begin
        outSlv_d.rvalid = 1'b0;
      end
      if (outArvalid && !outSlv_q.rvalid && !outSlv_q.arready) begin
        outSlv_d.arready = 1'b1;
        outSlv_d.rvalid  = 1'b1;
        outSlv_d.rresp   = (oHit == 2'h0) ? RESP_SLVERR : RESP_OKAY;
        outSlv_d.rdata   = (oHit == 2'h1) ? outCap0_q :
                           (oHit == 2'h2) ? outCap1_q : RESET_VALUE;
      end
      inPort0_d = inReg0_d[PortWidth-1:0];
      inPort1_d = inReg1_d[PortWidth-1:0];
    end
  end

  always_ff @(posedge clk) begin
    inReg0_q  <= inReg0_d;
    inReg1_q  <= inReg1_d;
    outCap0_q <= outCap0_d;
    outCap1_q <= outCap1_d;
    inSlv_q   <= inSlv_d;
    outSlv_q  <= outSlv_d;
    inPort0_q <= inPort0_d;
    inPort1_q <= inPort1_d;
  end

  // ****************************************************************
  // Port drive, all straight from flip-flops
  // ****************************************************************
  assign inAwready           = inSlv_q.awready;
  assign inWready            = inSlv_q.wready;
  assign inBvalid            = inSlv_q.bvalid;
  assign inBresp             = inSlv_q.bresp;
  assign inArready           = inSlv_q.arready;
  assign inRvalid            = inSlv_q.rvalid;
  assign inRdata             = inSlv_q.rdata;
  assign inRresp             = inSlv_q.rresp;
  assign outAwready          = outSlv_q.awready;
  assign outWready           = outSlv_q.wready;
  assign outBvalid           = outSlv_q.bvalid;
  assign outBresp            = outSlv_q.bresp;
  assign outArready          = outSlv_q.arready;
  assign outRvalid           = outSlv_q.rvalid;
  assign outRdata            = outSlv_q.rdata;
  assign outRresp            = outSlv_q.rresp;
  assign inputPortWordFirst  = inPort0_q;
  assign inputPortWordSecond = inPort1_q;

  // Write data on the read-only group is accepted and dropped.
  logic unusedOut;
  assign unusedOut = ^{outAwaddr, outWdata, outWstrb};

endmodule : axil_gateway_register_map
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import agrm_pkg::*;
();
  logic clk, rst, ce, bReady, rReady;
  logic [1:0] wv, rv, inBresp, inRresp, outBresp, outRresp;
  logic [2:0] awAddr, arAddr;
  logic [3:0] wStrb;
  logic [31:0] wData, inRdata, outRdata;
  logic [15:0] inputPortWordFirst, inputPortWordSecond, outputPortWordFirst, outputPortWordSecond;
  logic inAwready, inWready, inBvalid, inArready, inRvalid;
  logic outAwready, outWready, outBvalid, outArready, outRvalid;
  int err_count, samples_checked, cyc;
  axil_gateway_register_map i_axil_gateway_register_map (.clk, .rst, .ce,
    .inAwaddr(awAddr), .inAwvalid(wv[0]), .inAwready, .inWdata(wData), .inWstrb(wStrb),
    .inWvalid(wv[0]), .inWready, .inBresp, .inBvalid, .inBready(bReady), .inAraddr(arAddr),
    .inArvalid(rv[0]), .inArready, .inRdata, .inRresp, .inRvalid, .inRready(rReady),
    .outAwaddr(awAddr), .outAwvalid(wv[1]), .outAwready, .outWdata(wData), .outWstrb(wStrb),
    .outWvalid(wv[1]), .outWready, .outBresp, .outBvalid, .outBready(bReady),
    .outAraddr(arAddr), .outArvalid(rv[1]), .outArready, .outRdata, .outRresp, .outRvalid,
    .outRready(rReady), .inputPortWordFirst, .inputPortWordSecond, .outputPortWordFirst,
    .outputPortWordSecond);
  agrm_app_model i_agrm_app_model (.clk, .inFirst(inputPortWordFirst),
    .inSecond(inputPortWordSecond), .outFirst(outputPortWordFirst),
    .outSecond(outputPortWordSecond));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Holds ce low for h cycles first, so a parked request must not move.
  task automatic wr(input logic s, input logic [2:0] a, input logic [31:0] d,
                    input logic [3:0] st, input logic [1:0] er, input int h);
    awAddr <= a;
    wData  <= d;
    wStrb  <= st;
    wv[s]  <= 1'b1;
    if (h > 0) begin
      ce <= 1'b0;
      repeat (h) @(posedge clk);
      ce <= 1'b1;
    end
    do @(posedge clk); while (!(s ? outAwready : inAwready));
    wv     <= 2'b00;
    bReady <= 1'b1;
    chk("bresp", {30'h0, er}, {30'h0, s ? outBresp : inBresp});
    chk("bvalid", 32'h1, {31'h0, s ? outBvalid : inBvalid});
    chk("wready", 32'h1, {31'h0, s ? outWready : inWready});
    @(posedge clk);
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic s, input logic [2:0] a, input logic [31:0] e);
    arAddr <= a;
    rv[s]  <= 1'b1;
    do @(posedge clk); while (!(s ? outArready : inArready));
    rv     <= 2'b00;
    rReady <= 1'b1;
    chk("rdata", e, s ? outRdata : inRdata);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, s ? outRresp : inRresp});
    chk("rvalid", 32'h1, {31'h0, s ? outRvalid : inRvalid});
    @(posedge clk);
    rReady <= 1'b0;
  endtask : rd
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Free-running clock and a hang guard far above the expected run length.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (++cyc > 9000) begin
    err_count++;
    end_of_test();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1; ce = 1'b1; wv = 2'b00; rv = 2'b00; bReady = 1'b0; rReady = 1'b0;
    awAddr = 3'h0; arAddr = 3'h0; wData = 32'h0; wStrb = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(1'b0, 3'h0, 32'h0000_0000);
    wr(1'b0, 3'h0, 32'hFFFF_1234, 4'hF, RESP_OKAY, 0);
    wr(1'b0, 3'h4, 32'h0000_ABCD, 4'hF, RESP_OKAY, 3);
    rd(1'b0, 3'h0, 32'h0000_1234);
    rd(1'b0, 3'h4, 32'h0000_ABCD);
    chk("portFirst", 32'h0000_1234, {16'h0, inputPortWordFirst});
    chk("portSecond", 32'h0000_ABCD, {16'h0, inputPortWordSecond});
    rd(1'b1, 3'h0, 32'h0000_5432);
    rd(1'b1, 3'h4, 32'h0000_1234);
    wr(1'b1, 3'h0, 32'h0000_FFFF, 4'hF, RESP_SLVERR, 0);
    rd(1'b1, 3'h0, 32'h0000_5432);
    wr(1'b0, 3'h0, 32'h0000_00EE, 4'h1, RESP_OKAY, 0);
    rd(1'b0, 3'h0, 32'h0000_12EE);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(1'b0, 3'h4, 32'h0000_0000);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
